/* tb/i2c_master_model.sv */
`timescale 1ns/1ns
// ****
// bus master
// ****
module i2c_master_model
(
	input wire logic ref_clk,
	input wire logic sda_line,
	output logic     scl,
	output logic     sda_drv
);
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task q(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// data moves only while scl is low
	task bt(input logic b, output logic r);
		q(2);
		sda_drv = b;
		q(2);
		scl = 1'b1;
		q(4);
		r = sda_line;
		scl = 1'b0;
	endtask
	task start;
		q(2);
		sda_drv = 1'b1;
		q(2);
		scl = 1'b1;
		q(4);
		sda_drv = 1'b0;
		q(4);
		scl = 1'b0;
	endtask
	task stop;
		q(2);
		sda_drv = 1'b0;
		q(2);
		scl = 1'b1;
		q(4);
		sda_drv = 1'b1;
		q(4);
	endtask
	// ai low asks for one more byte; released line reads as the pull-up
	task xb(input logic [7:0] d, input logic ai, output logic [7:0] r, output logic ao);
		for (int i = 7; i >= 0; i--)
			bt(d[i], r[i]);
		bt(ai, ao);
	endtask
endmodule // i2c_master_model

/* tb/switch_access_assertions.sv */
`timescale 1ns/1ns
// ****
// port checks
// ****
module switch_access_checker
(
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       clk_en,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe_n,
	input wire logic       busy,
	input wire logic [7:0] channel_select_reg,
	input wire logic [7:0] configuration_reg
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_start;
		clk_en && scl_in && $past(scl_in) && $fell(sda_in);
	endsequence
	AST_RESET_STATE: assert property ($rose(rst_n) |-> sda_oe_n && !busy && channel_select_reg == 8'h00)
		else $error("bad state after reset");
	AST_DRIVE_LOW: assert property (!sda_oe_n |-> !sda_out)
		else $error("sda driven high");
	AST_START_BUSY: assert property (s_start |-> ##[1:3] busy)
		else $error("start not taken");
	AST_STOP_IDLE: assert property (clk_en && scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:3] !busy)
		else $error("stop not taken");
	AST_HOLD_SCL_HIGH: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
		else $error("sda moved with scl high");
	AST_IDLE_RELEASED: assert property (!busy && !$past(busy) |-> sda_oe_n)
		else $error("sda driven while idle");
	AST_SELECT_IN_TXN: assert property ($changed(channel_select_reg) |-> busy || $past(busy) || $past(busy, 2))
		else $error("select changed outside transfer");
	AST_CONFIG_SCL_LOW: assert property ($changed(configuration_reg) |-> !scl_in)
		else $error("configuration changed with scl high");
	AST_FREEZE: assert property (!clk_en |=> $stable(sda_oe_n) && $stable(channel_select_reg))
		else $error("state moved while frozen");
	cover property (s_start);
	cover property (!sda_oe_n && scl_in);
	cover property ($changed(configuration_reg));
endmodule // switch_access_checker

bind i2c_switch_register_access switch_access_checker chk_i (.ref_clk, .rst_n, .clk_en, .scl_in, .sda_in,
	.sda_out, .sda_oe_n, .busy, .channel_select_reg, .configuration_reg);

/* tb/tb_i2c_switch_register_access.sv */
`timescale 1ns/1ns
// ****
// scenarios
// ****
module tb_i2c_switch_register_access;
	localparam logic [6:0] A = switch_regs_pkg::DEFAULT_SLAVE_ADDR;
	logic       ref_clk;
	logic       rst_n;
	logic       clk_en;
	logic       mode;
	logic       scl;
	logic       sda_drv;
	logic       sda_out;
	logic       sda_oe_n;
	logic       busy;
	logic [7:0] ch;
	logic [7:0] cf;
	logic [7:0] fl;
	logic [7:0] st3;
	logic [7:0] st4;
	logic [7:0] st5;
	logic [7:0] st6;
	logic [7:0] r;
	logic       a;
	int         n_mismatch;
	int         checked;
	wire        sda = sda_drv & (sda_oe_n | sda_out);
	i2c_switch_register_access #(.SLAVE_ADDR(A)) dut (.ref_clk, .rst_n, .clk_en, .scl_in(scl), .sda_in(sda),
		.sda_out, .sda_oe_n, .enhanced_mode(mode), .status_reg3(st3), .status_reg4(st4),
		.status_reg5(st5), .status_reg6(st6), .channel_select_reg(ch), .configuration_reg(cf),
		.flush_out_sequence_reg(fl), .busy);
	i2c_master_model m (.ref_clk, .sda_line(sda), .scl, .sda_drv);
	always #20 ref_clk = ~ref_clk;
	task chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("unexpected %0t seen %h want %h", $time, s, e);
		end
	endtask
	task complete_run;
		if (n_mismatch == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task open(input logic rw);
		m.start();
		m.xb({A, rw}, 1'b1, r, a);
		chk({7'h00, a}, 8'h00);
	endtask
	task wb(input logic [7:0] d);
		m.xb(d, 1'b1, r, a);
		chk({7'h00, a}, 8'h00);
	endtask
	task rb(input logic [7:0] e, input logic last);
		m.xb(8'hff, last, r, a);
		chk(r, e);
	endtask
	task t_enh_write;
		mode = 1'b1;
		open(1'b0);
		wb(8'ha1);
		m.q(3);
		chk(ch, 8'ha1);
		wb(8'hb2);
		wb(8'hc3);
		wb(8'hd4);
		m.q(3);
		chk(ch, 8'hd4);
		chk(cf, 8'hb2);
		chk(fl, 8'hc3);
		m.stop();
	endtask
	task t_enh_read;
		logic [7:0] e [7];
		e = '{8'hd4, 8'hb2, 8'hc3, 8'h33, 8'h44, 8'h55, 8'h66};
		open(1'b1);
		for (int i = 0; i < 9; i++)
			rb(e[i % 7], i == 8);
		m.stop();
	endtask
	task t_restart;
		open(1'b0);
		wb(8'h77);
		open(1'b1);
		rb(8'h77, 1'b0);
		rb(8'hb2, 1'b1);
		m.stop();
		open(1'b1);
		rb(8'h77, 1'b1);
		m.stop();
	endtask
	task t_basic;
		mode = 1'b0;
		open(1'b0);
		mode = 1'b1;
		wb(8'h11);
		wb(8'h5a);
		m.q(3);
		chk(ch, 8'h77);
		chk(cf, 8'hb2);
		m.stop();
		m.q(3);
		chk(ch, 8'h5a);
		mode = 1'b0;
		open(1'b1);
		rb(8'h5a, 1'b0);
		rb(8'h5a, 1'b0);
		rb(8'h5a, 1'b1);
		m.stop();
	endtask
	task t_no_data;
		open(1'b0);
		m.stop();
		m.start();
		m.xb({A ^ 7'h01, 1'b0}, 1'b1, r, a);
		chk({7'h00, a}, 8'h01);
		m.stop();
		// a STOP missed while frozen leaves the held byte uncommitted
		open(1'b0);
		wb(8'h3c);
		m.q(3);
		clk_en = 1'b0;
		m.stop();
		clk_en = 1'b1;
		m.q(3);
		chk(ch, 8'h5a);
		chk({7'h00, busy}, 8'h01);
		// a new START drops the held byte
		m.start();
		m.stop();
		m.q(3);
		chk({7'h00, busy}, 8'h00);
		chk(ch, 8'h5a);
	endtask
	initial
	begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		mode = 1'b1;
		n_mismatch = 0;
		checked = 0;
		st3 = 8'h33;
		st4 = 8'h44;
		st5 = 8'h55;
		st6 = 8'h66;
		repeat (3) @(negedge ref_clk);
		rst_n = 1'b1;
		t_enh_write;
		t_enh_read;
		t_restart;
		t_basic;
		t_no_data;
		complete_run;
	end
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		complete_run;
	end
endmodule // tb_i2c_switch_register_access

/* verilog/i2c_switch_register_access.sv */
`timescale 1ns/1ns

module i2c_switch_register_access
#(
	parameter logic [6:0] SLAVE_ADDR = switch_regs_pkg::DEFAULT_SLAVE_ADDR
)
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	input  wire logic        enhanced_mode,
	input  wire logic [7:0]  status_reg3,
	input  wire logic [7:0]  status_reg4,
	input  wire logic [7:0]  status_reg5,
	input  wire logic [7:0]  status_reg6,
	output logic      [7:0]  channel_select_reg,
	output logic      [7:0]  configuration_reg,
	output logic      [7:0]  flush_out_sequence_reg,
	output logic             busy
);

	typedef enum logic [2:0] {
		IDLE,
		ADDR,
		ADDR_ACK,
		WR_DATA,
		WR_ACK,
		RD_DATA,
		RD_ACK
	} state_type;

	// ****************************************
	// line sampling and conditions
	// ****************************************
	logic       scl_prev_reg;
	logic       sda_prev_reg;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_seen;
	logic       stop_seen;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end
		else if (clk_en)
		begin
			scl_prev_reg <= scl_in;
			sda_prev_reg <= sda_in;
		end
	end

	assign scl_rise   = scl_in && !scl_prev_reg;
	assign scl_fall   = !scl_in && scl_prev_reg;
	assign start_seen = scl_in && scl_prev_reg && sda_prev_reg && !sda_in;
	assign stop_seen  = scl_in && scl_prev_reg && !sda_prev_reg && sda_in;

	// ****************************************
	// byte engine
	// ****************************************
	state_type  state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic       enhanced_reg;
	logic       pending_reg;
	logic [7:0] pending_data_reg;
	logic [7:0] rd_byte;
	logic       master_nack_reg;
	logic [2:0] ptr;
	logic       restart;
	switch_regs_pkg::ptr_op_type ptr_op;
	logic       addr_match;

	// address sits above the direction bit once all eight bits are in
	assign addr_match = (shift_reg[7:1] == SLAVE_ADDR);
	assign restart    = start_seen;
	assign busy       = (state_reg != IDLE);

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state_reg       <= IDLE;
			bit_cnt_reg     <= 4'h0;
			shift_reg       <= 8'h00;
			master_nack_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (start_seen)
			begin
				state_reg   <= ADDR;
				bit_cnt_reg <= 4'h0;
			end
			else if (stop_seen)
				state_reg <= IDLE;
			else
			begin
				unique case (state_reg)
					IDLE: ;
					ADDR, WR_DATA:
					begin
						if (scl_rise)
						begin
							shift_reg   <= {shift_reg[6:0], sda_in};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
						if (scl_fall && bit_cnt_reg == switch_regs_pkg::BIT_ACK)
						begin
							if (state_reg == WR_DATA)
								state_reg <= WR_ACK;
							else if (addr_match)
								state_reg <= ADDR_ACK;
							else
								state_reg <= IDLE;
						end
					end
					ADDR_ACK:
					begin
						if (scl_fall)
						begin
							bit_cnt_reg <= 4'h0;
							state_reg   <= shift_reg[0] ? RD_DATA : WR_DATA;
						end
					end
					WR_ACK:
					begin
						if (scl_fall)
						begin
							bit_cnt_reg <= 4'h0;
							state_reg   <= WR_DATA;
						end
					end
					RD_DATA:
					begin
						if (scl_fall)
						begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							if (bit_cnt_reg == switch_regs_pkg::BIT_LAST_DATA)
								state_reg <= RD_ACK;
						end
					end
					RD_ACK:
					begin
						if (scl_rise)
							master_nack_reg <= sda_in;
						if (scl_fall)
						begin
							bit_cnt_reg <= 4'h0;
							state_reg   <= master_nack_reg ? IDLE : RD_DATA;
						end
					end
				endcase
			end
		end
	end

	// ****************************************
	// mode sampling
	// ****************************************
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			enhanced_reg <= 1'b0;
		else if (clk_en && start_seen)
			enhanced_reg <= enhanced_mode;
	end

	// ****************************************
	// pointer
	// ****************************************
	always_comb
	begin
		ptr_op = switch_regs_pkg::PTR_HOLD;
		if (state_reg == WR_ACK && scl_fall)
			ptr_op = switch_regs_pkg::PTR_WRITE;
		else if (state_reg == RD_ACK && scl_fall)
			ptr_op = switch_regs_pkg::PTR_READ;
	end

	reg_pointer u_ptr
	(
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.clk_en   (clk_en),
		.restart  (restart),
		.enhanced (enhanced_reg),
		.op       (ptr_op),
		.ptr      (ptr)
	);

	// ****************************************
	// register writes
	// ****************************************
	logic wr_strobe;
	assign wr_strobe = (state_reg == WR_DATA) && scl_fall && (bit_cnt_reg == switch_regs_pkg::BIT_ACK);

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			channel_select_reg     <= switch_regs_pkg::RESET_CHANNEL;
			configuration_reg      <= switch_regs_pkg::RESET_CONFIG;
			flush_out_sequence_reg <= switch_regs_pkg::RESET_FLUSH;
		end
		else if (clk_en)
		begin
			if (wr_strobe && enhanced_reg)
			begin
				unique case (ptr)
					switch_regs_pkg::OFS_CHANNEL_SELECT: channel_select_reg     <= shift_reg;
					switch_regs_pkg::OFS_CONFIGURATION:  configuration_reg      <= shift_reg;
					switch_regs_pkg::OFS_FLUSH_OUT:      flush_out_sequence_reg <= shift_reg;
					default: ;
				endcase
			end
			else if (stop_seen && pending_reg && !enhanced_reg)
				channel_select_reg <= pending_data_reg;
		end
	end

	// basic mode holds the last byte until STOP so a torn write never reaches the switch
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			pending_reg      <= 1'b0;
			pending_data_reg <= 8'h00;
		end
		else if (clk_en)
		begin
			if (start_seen || stop_seen)
				pending_reg <= 1'b0;
			else if (wr_strobe && !enhanced_reg)
			begin
				pending_reg      <= 1'b1;
				pending_data_reg <= shift_reg;
			end
		end
	end

	// ****************************************
	// read data and SDA drive
	// ****************************************
	always_comb
	begin
		unique case (ptr)
			switch_regs_pkg::OFS_CHANNEL_SELECT: rd_byte = channel_select_reg;
			switch_regs_pkg::OFS_CONFIGURATION:  rd_byte = configuration_reg;
			switch_regs_pkg::OFS_FLUSH_OUT:      rd_byte = flush_out_sequence_reg;
			switch_regs_pkg::OFS_STATUS_3:       rd_byte = status_reg3;
			switch_regs_pkg::OFS_STATUS_4:       rd_byte = status_reg4;
			switch_regs_pkg::OFS_STATUS_5:       rd_byte = status_reg5;
			switch_regs_pkg::OFS_STATUS_6:       rd_byte = status_reg6;
			default:                             rd_byte = 8'h00;
		endcase
	end

	// sda changes only on SCL low, apart from the release on START or STOP, keeping data stable while SCL is high
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			sda_out  <= 1'b1;
			sda_oe_n <= 1'b1;
		end
		else if (clk_en)
		begin
			if (start_seen || stop_seen)
			begin
				sda_out  <= 1'b1;
				sda_oe_n <= 1'b1;
			end
			else if (!scl_in)
			begin
				if (state_reg == ADDR_ACK || state_reg == WR_ACK)
				begin
					sda_out  <= 1'b0;
					sda_oe_n <= 1'b0;
				end
				else if (state_reg == RD_DATA && bit_cnt_reg <= switch_regs_pkg::BIT_LAST_DATA)
				begin
					sda_out  <= 1'b0;
					sda_oe_n <= rd_byte[3'h7 - bit_cnt_reg[2:0]];
				end
				else
				begin
					sda_out  <= 1'b1;
					sda_oe_n <= 1'b1;
				end
			end
		end
	end

endmodule // i2c_switch_register_access

/* verilog/reg_pointer.sv */
`timescale 1ns/1ns

// pointer for register access; wrap limits differ for writes and reads
module reg_pointer
(
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	input  wire logic                        clk_en,
	input  wire logic                        restart,
	input  wire logic                        enhanced,
	input  wire switch_regs_pkg::ptr_op_type op,
	output logic      [2:0]                  ptr
);

	// ****************************************
	// pointer update
	// ****************************************
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			ptr <= switch_regs_pkg::OFS_CHANNEL_SELECT;
		else if (clk_en)
		begin
			if (restart)
				ptr <= switch_regs_pkg::OFS_CHANNEL_SELECT;
			else if (!enhanced)
				ptr <= switch_regs_pkg::OFS_CHANNEL_SELECT;
			else if (op == switch_regs_pkg::PTR_WRITE)
				ptr <= (ptr == switch_regs_pkg::OFS_LAST_WRITABLE) ? switch_regs_pkg::OFS_CHANNEL_SELECT
					: ptr + 3'h1;
			else if (op == switch_regs_pkg::PTR_READ)
				ptr <= (ptr == switch_regs_pkg::OFS_LAST_READABLE) ? switch_regs_pkg::OFS_CHANNEL_SELECT
					: ptr + 3'h1;
		end
	end

endmodule // reg_pointer

/* verilog/switch_regs_pkg.sv */
package switch_regs_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int          REG_COUNT           = 7;
	localparam int          WRITABLE_COUNT      = 3;
	localparam logic [2:0]  OFS_CHANNEL_SELECT  = 3'h0;
	localparam logic [2:0]  OFS_CONFIGURATION   = 3'h1;
	localparam logic [2:0]  OFS_FLUSH_OUT       = 3'h2;
	localparam logic [2:0]  OFS_LAST_WRITABLE   = 3'h2;
	localparam logic [2:0]  OFS_LAST_READABLE   = 3'h6;
	localparam logic [2:0]  OFS_STATUS_3        = 3'h3;
	localparam logic [2:0]  OFS_STATUS_4        = 3'h4;
	localparam logic [2:0]  OFS_STATUS_5        = 3'h5;
	localparam logic [2:0]  OFS_STATUS_6        = 3'h6;
	localparam logic [7:0]  RESET_CHANNEL       = 8'h00;
	localparam logic [7:0]  RESET_CONFIG        = 8'h00;
	localparam logic [7:0]  RESET_FLUSH         = 8'h00;

	// ****************************************
	// serial framing
	// ****************************************
	localparam logic [3:0]  BIT_LAST_DATA       = 4'h7;
	localparam logic [3:0]  BIT_ACK             = 4'h8;
	localparam logic [6:0]  DEFAULT_SLAVE_ADDR  = 7'h70;

	typedef enum logic [1:0] {
		PTR_HOLD,
		PTR_WRITE,
		PTR_READ
	} ptr_op_type;

endpackage
